// File: pwr_rst_pkg.sv
// shared constants and types of the power-down and reset controller
package pwr_rst_pkg;

   // register byte addresses
   localparam logic [7:0]  ADR_PWR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_UNLOCK     = 8'h04;
   localparam logic [7:0]  ADR_INT_EN     = 8'h08;
   localparam logic [7:0]  ADR_STATUS     = 8'h0C;
   localparam logic [7:0]  ADR_PORTS      = 8'h10;
   localparam logic [7:0]  ADR_WDCTL      = 8'hD8;

   // power control register fields
   localparam int          PC_PDOWN       = 1;
   localparam int          PC_STRB_LVL    = 4;
   localparam logic [7:0]  PC_MASK        = 8'h10;
   localparam logic [7:0]  PC_RESET       = 8'h00;

   // interrupt enable register fields
   localparam int          IE_EX0         = 0;
   localparam int          IE_EX1         = 2;
   localparam int          IE_GLOBAL      = 7;
   localparam logic [7:0]  IE_MASK        = 8'h85;
   localparam logic [7:0]  IE_RESET       = 8'h00;

   // watchdog control register fields
   localparam int          WD_POR         = 6;
   localparam int          WD_TOF         = 3;
   localparam int          WD_RSTF        = 2;
   localparam int          WD_REN         = 1;
   localparam int          WD_RESTART     = 0;
   localparam logic [7:0]  WD_VALID       = 8'h4F;
   localparam logic [7:0]  WD_RESET       = 8'h40;

   // timed access keys and window
   localparam logic [7:0]  TA_KEY1        = 8'hAA;
   localparam logic [7:0]  TA_KEY2        = 8'h55;
   localparam logic [4:0]  TA_OPEN_CLKS   = 5'd16;

   // timing
   localparam logic [1:0]  MC_LAST        = 2'd3;
   localparam int          MC_CLKS        = 4;
   localparam logic [1:0]  EXT_RST_MC     = 2'd2;
   localparam logic [1:0]  EXT_REL_MC     = 2'd2;
   localparam int          WDT_RST_MC     = 2;
   localparam logic [3:0]  WDT_HOLD_LAST  = 4'(WDT_RST_MC * MC_CLKS - 1);
   localparam int          WDT_GRACE_CLKS = 512;

   // reset values loaded into the processor side
   localparam logic [31:0] PORT_RESET     = 32'hFFFF_FFFF;
   localparam logic [15:0] PC_START       = 16'h0000;
   localparam logic [7:0]  SP_START       = 8'h07;

   typedef enum logic [1:0]
   {
      PWR_RUN  = 2'b00,
      PWR_DOWN = 2'b01,
      PWR_WAKE = 2'b11
   } pwr_state_t;

endpackage : pwr_rst_pkg

// File: ext_reset_filter.sv
// reset pin qualifier: samples once per machine cycle, holds and releases
`timescale 1ns/1ps
`default_nettype none
module ext_reset_filter
   import pwr_rst_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ph4_i,
   input  wire logic pd_i,
   input  wire logic pin_i,
   output var  logic hold_o
);
   import pwr_rst_pkg::*;

   typedef struct packed {
      logic       hold;
      logic [1:0] hi_cnt;
      logic [1:0] lo_cnt;
   } flt_t;

   flt_t q_ff;
   flt_t nxt_q;

   always_comb
   begin
      nxt_q = q_ff;
      // R5 - pin high ends power-down
      if (pd_i && pin_i)
      begin
         nxt_q.hold   = 1'b1;
         nxt_q.hi_cnt = EXT_RST_MC;
         nxt_q.lo_cnt = 2'd0;
      end
      // R9 - sample in fourth clock phase
      else if (ph4_i)
      begin
         if (pin_i)
         begin
            nxt_q.lo_cnt = 2'd0;
            if (q_ff.hi_cnt < EXT_RST_MC)
               nxt_q.hi_cnt = q_ff.hi_cnt + 2'd1;
            if (q_ff.hi_cnt + 2'd1 >= EXT_RST_MC)
               nxt_q.hold = 1'b1;
         end
         else
         begin
            nxt_q.hi_cnt = 2'd0;
            // R10 - release two machine cycles later
            if (q_ff.hold)
            begin
               if (q_ff.lo_cnt + 2'd1 >= EXT_REL_MC)
               begin
                  nxt_q.hold   = 1'b0;
                  nxt_q.lo_cnt = 2'd0;
               end
               else
                  nxt_q.lo_cnt = q_ff.lo_cnt + 2'd1;
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q_ff <= '0;
      else
         q_ff <= nxt_q;
   end

   assign hold_o = q_ff.hold;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_hold_needs_pin: assert property ($rose(q_ff.hold) |-> $past(pin_i)) // R9
      else $error("reset hold rose without pin high");
   a_hold_release: assert property ($fell(q_ff.hold) |-> $past(!pin_i && ph4_i)) // R10
      else $error("reset hold fell while pin high or off phase");
   a_two_samples: assert property
      ((!pd_i && ph4_i && pin_i && q_ff.hi_cnt == 2'd0 && !q_ff.hold) |=> !q_ff.hold) // R9
      else $error("reset taken after a single sample");

endmodule : ext_reset_filter
`default_nettype wire

// File: powerdown_and_reset_control.sv
// power-down entry and exit, reset sources and reset cause flags
// Notes on behaviour
// R1 - power-down bit write halts the device
// R2 - all clocks stop during power-down
// R3 - strobes follow level select in power-down
// R4 - ports hold data; port 0 floats externally
// R5 - reset pin high exits power-down, restarts
// R6 - watchdog cannot end power-down
// R7 - enabled low interrupt pin wakes device
// R8 - wake runs matching interrupt, then resumes
// R9 - pin sampled each fourth phase, two cycles
// R10 - reset lasts until two cycles after pin
// R11 - external reset sets no cause flag
// R12 - power-on reset sets power-on flag
// R13 - timeout flag, reset 512 clocks later
// R14 - watchdog reset held two cycles, flagged
// R15 - power-on reset disables watchdog
// R16 - reset loads ports, counter, stack pointer
// R17 - reset leaves data RAM untouched
// R18 - external reset pattern, reset flag kept
// R19 - reset flag set/cleared by source
// R20 - only power-on clears reset enable
// R21 - protected bits need timed access unlock
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module powerdown_and_reset_control
   import pwr_rst_pkg::*;
#(
   parameter int GRACE_CLKS = WDT_GRACE_CLKS
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic        reset_pin_i,
   input  wire logic        supply_low_i,
   input  wire logic        int0_n_i,
   input  wire logic        int1_n_i,
   input  wire logic        wdt_timeout_i,
   input  wire logic        ale_core_i,
   input  wire logic        store_strobe_core_i,
   input  wire logic        ext_prog_i,
   output var  logic        clk_run_o,
   output var  logic        cpu_reset_o,
   output var  logic [15:0] start_pc_o,
   output var  logic [7:0]  start_sp_o,
   output var  logic        ale_o,
   output var  logic        store_strobe_o,
   output var  logic [31:0] port_o,
   output var  logic        port0_oe_o,
   output var  logic        wdt_restart_o,
   output var  logic        wdt_reset_enable_o,
   output var  logic        wake_int0_o,
   output var  logic        wake_int1_o
);
   import pwr_rst_pkg::*;

   localparam logic [9:0] GRACE_LAST = 10'(GRACE_CLKS - 1);

   typedef struct packed {
      logic [3:0]  sync1;
      logic [3:0]  sync2;
      logic [1:0]  phase;
      pwr_state_t  pwr;
      logic [7:0]  pctl;
      logic [7:0]  ie;
      logic [7:0]  wd;
      logic [31:0] ports;
      logic        unl_armed;
      logic        unl_open;
      logic [4:0]  unl_cnt;
      logic        wdt_pend;
      logic [9:0]  grace;
      logic        wdt_hold;
      logic [3:0]  hold_cnt;
      logic [1:0]  wake_src;
      logic        ack;
      logic [31:0] rdat;
      logic        clk_run;
      logic        cpu_rst;
      logic [15:0] pc;
      logic [7:0]  sp;
      logic        ale;
      logic        store_strobe;
      logic        p0_oe;
      logic        wdt_restart;
      logic        wake0;
      logic        wake1;
   } ctl_t;

   ctl_t q_ff;
   ctl_t nxt_q;

   logic       ext_hold;
   logic       ph4;
   logic       pd;
   logic       por_now;
   logic       chip_rst;
   logic       req;
   logic       wr;
   logic [1:0] wake_pins;
   logic [7:0] pctl_rd;

   // sync order: 0 reset pin, 1 supply low, 2 int0, 3 int1
   assign pd        = (q_ff.pwr == PWR_DOWN);
   assign ph4       = (q_ff.phase == MC_LAST) && !pd;
   assign por_now   = q_ff.sync2[1];
   assign chip_rst  = ext_hold | por_now | q_ff.wdt_hold;
   assign req       = wb_cyc_i & wb_stb_i & ~q_ff.ack;
   assign wr        = req & wb_we_i & wb_sel_i[0];
   // R7 - wake needs pin low, enable and global enable
   assign wake_pins = {q_ff.ie[IE_EX1] & ~q_ff.sync2[3], q_ff.ie[IE_EX0] & ~q_ff.sync2[2]}
                      & {2{q_ff.ie[IE_GLOBAL]}};

   ext_reset_filter u_ext_filter
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ph4_i  (ph4),
      .pd_i   (pd),
      .pin_i  (q_ff.sync2[0]),
      .hold_o (ext_hold)
   );

   always_comb
   begin
      nxt_q             = q_ff;
      pctl_rd           = q_ff.pctl;
      pctl_rd[PC_PDOWN] = pd;
      nxt_q.sync1       = {int1_n_i, int0_n_i, supply_low_i, reset_pin_i};
      nxt_q.sync2       = q_ff.sync1;
      nxt_q.wdt_restart = 1'b0;
      // R2 - divider halts with the clocks
      if (!pd)
         nxt_q.phase = q_ff.phase + 2'd1;

      if (q_ff.unl_cnt != 5'd0)
         nxt_q.unl_cnt = q_ff.unl_cnt - 5'd1;
      else
      begin
         nxt_q.unl_armed = 1'b0;
         nxt_q.unl_open  = 1'b0;
      end

      // bus slave: ack one cycle after the strobe
      nxt_q.ack  = req;
      nxt_q.rdat = 32'h0000_0000;
      if (req && !wb_we_i)
      begin
         case (wb_adr_i)
            ADR_PWR_CTRL: nxt_q.rdat = {24'h00_0000, pctl_rd};
            ADR_INT_EN:   nxt_q.rdat = {24'h00_0000, q_ff.ie};
            ADR_STATUS:   nxt_q.rdat = {28'h000_0000, q_ff.wake_src, q_ff.cpu_rst, pd};
            ADR_PORTS:    nxt_q.rdat = q_ff.ports;
            // R21 - only WD_VALID bits readable, others read 0
            ADR_WDCTL:    nxt_q.rdat = {24'h00_0000, q_ff.wd & WD_VALID};
            default:      nxt_q.rdat = 32'h0000_0000;
         endcase
      end
      if (req && wb_we_i && wb_adr_i == ADR_PORTS)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wb_sel_i[b])
               nxt_q.ports[8*b +: 8] = wb_dat_i[8*b +: 8];
         end
      end
      if (wr)
      begin
         case (wb_adr_i)
            ADR_PWR_CTRL: nxt_q.pctl = wb_dat_i[7:0] & PC_MASK;
            ADR_INT_EN:   nxt_q.ie   = wb_dat_i[7:0] & IE_MASK;
            ADR_UNLOCK:
            begin
               nxt_q.unl_open  = 1'b0;
               nxt_q.unl_armed = 1'b0;
               if (wb_dat_i[7:0] == TA_KEY1)
               begin
                  nxt_q.unl_armed = 1'b1;
                  nxt_q.unl_cnt   = TA_OPEN_CLKS;
               end
               else if (q_ff.unl_armed && wb_dat_i[7:0] == TA_KEY2)
               begin
                  nxt_q.unl_open = 1'b1;
                  nxt_q.unl_cnt  = TA_OPEN_CLKS;
               end
            end
            ADR_WDCTL:
            begin
               nxt_q.wd[WD_RSTF] = wb_dat_i[WD_RSTF];
               // R21 - protected bits only after unlock
               if (q_ff.unl_open)
               begin
                  nxt_q.wd[WD_POR] = wb_dat_i[WD_POR];
                  nxt_q.wd[WD_TOF] = wb_dat_i[WD_TOF];
                  nxt_q.wd[WD_REN] = wb_dat_i[WD_REN];
                  nxt_q.unl_open   = 1'b0;
                  if (wb_dat_i[WD_RESTART])
                  begin
                     nxt_q.wdt_restart = 1'b1;
                     nxt_q.wdt_pend    = 1'b0;
                     nxt_q.grace       = 10'd0;
                  end
               end
            end
            default: ;
         endcase
      end

      // R6 - watchdog path frozen while powered down
      if (!pd && !chip_rst)
      begin
         // R13 - grace count after timeout, then reset
         if (q_ff.wdt_pend && !nxt_q.wdt_restart)
         begin
            if (q_ff.grace == GRACE_LAST)
            begin
               nxt_q.wdt_pend = 1'b0;
               if (q_ff.wd[WD_REN])
               begin
                  nxt_q.wdt_hold = 1'b1;
                  nxt_q.hold_cnt = 4'd0;
               end
            end
            else
               nxt_q.grace = q_ff.grace + 10'd1;
         end
         // R13 - timeout sets flag, wins over clear
         if (wdt_timeout_i)
         begin
            nxt_q.wd[WD_TOF] = 1'b1;
            nxt_q.wdt_pend   = 1'b1;
            nxt_q.grace      = 10'd0;
         end
      end
      // R14 - watchdog reset held two machine cycles
      if (q_ff.wdt_hold)
      begin
         if (q_ff.hold_cnt == WDT_HOLD_LAST)
            nxt_q.wdt_hold = 1'b0;
         else
            nxt_q.hold_cnt = q_ff.hold_cnt + 4'd1;
      end

      case (q_ff.pwr)
         PWR_RUN:
         begin
            // R1 - writing the bit halts after this access
            if (wr && wb_adr_i == ADR_PWR_CTRL && wb_dat_i[PC_PDOWN])
               nxt_q.pwr = PWR_DOWN;
         end
         PWR_DOWN:
         begin
            // R5 - any reset source restarts the clock
            if (chip_rst)
               nxt_q.pwr = PWR_RUN;
            else if (wake_pins != 2'b00)
            begin
               nxt_q.pwr      = PWR_WAKE;
               nxt_q.wake_src = wake_pins;
            end
         end
         PWR_WAKE: nxt_q.pwr = PWR_RUN;
         default:  nxt_q.pwr = PWR_RUN;
      endcase

      // R16 - reset loads ports and start values
      // R17 - stack pointer, counter and ports reloaded, no RAM clear
      if (chip_rst)
      begin
         nxt_q.pwr              = PWR_RUN;
         nxt_q.ports            = PORT_RESET;
         nxt_q.pc               = PC_START;
         nxt_q.sp               = SP_START;
         nxt_q.pctl             = PC_RESET;
         nxt_q.ie               = IE_RESET;
         nxt_q.unl_armed        = 1'b0;
         nxt_q.unl_open         = 1'b0;
         nxt_q.wdt_pend         = 1'b0;
         nxt_q.wake_src         = 2'b00;
         // R18 - external pattern clears timeout and restart
         // R11 - no flag of its own for the pin
         nxt_q.wd[WD_TOF]       = 1'b0;
         nxt_q.wd[WD_RESTART]   = 1'b0;
         // R12 - power-on sets its flag
         // R15 - power-on disables the watchdog reset
         // R20 - only power-on clears the enable
         if (por_now)
         begin
            nxt_q.wd[WD_POR]  = 1'b1;
            nxt_q.wd[WD_RSTF] = 1'b0;
            nxt_q.wd[WD_REN]  = 1'b0;
            nxt_q.wdt_hold    = 1'b0;
         end
         // R19 - watchdog reset sets the reset flag
         else if (q_ff.wdt_hold)
            nxt_q.wd[WD_RSTF] = 1'b1;
      end

      nxt_q.cpu_rst = chip_rst;
      nxt_q.clk_run = (nxt_q.pwr != PWR_DOWN);
      // R3 - strobe level select during power-down
      nxt_q.ale     = pd ? q_ff.pctl[PC_STRB_LVL] : ale_core_i;
      nxt_q.store_strobe = pd ? q_ff.pctl[PC_STRB_LVL] : store_strobe_core_i;
      // R4 - port 0 floats in power-down when running from external memory
      nxt_q.p0_oe   = !(pd && ext_prog_i);
      // R8 - one request pulse to the matching interrupt
      nxt_q.wake0   = (q_ff.pwr == PWR_WAKE) && q_ff.wake_src[0];
      nxt_q.wake1   = (q_ff.pwr == PWR_WAKE) && q_ff.wake_src[1];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q_ff         <= '0;
         q_ff.sync2   <= 4'hC;
         q_ff.sync1   <= 4'hC;
         q_ff.pwr     <= PWR_RUN;
         q_ff.wd      <= WD_RESET;
         q_ff.ports   <= PORT_RESET;
         q_ff.pc      <= PC_START;
         q_ff.sp      <= SP_START;
         q_ff.clk_run <= 1'b1;
         q_ff.p0_oe   <= 1'b1;
      end
      else
         q_ff <= nxt_q;
   end

   assign wb_dat_o           = q_ff.rdat;
   assign wb_ack_o           = q_ff.ack;
   assign clk_run_o          = q_ff.clk_run;
   assign cpu_reset_o        = q_ff.cpu_rst;
   assign start_pc_o         = q_ff.pc;
   assign start_sp_o         = q_ff.sp;
   assign ale_o              = q_ff.ale;
   assign store_strobe_o     = q_ff.store_strobe;
   assign port_o             = q_ff.ports;
   assign port0_oe_o         = q_ff.p0_oe;
   assign wdt_restart_o      = q_ff.wdt_restart;
   assign wdt_reset_enable_o = q_ff.wd[WD_REN];
   assign wake_int0_o        = q_ff.wake0;
   assign wake_int1_o        = q_ff.wake1;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pdown_entry: assert property // R1
      ((q_ff.pwr == PWR_RUN && !chip_rst && wr && wb_adr_i == ADR_PWR_CTRL
        && wb_dat_i[PC_PDOWN]) |=> q_ff.pwr == PWR_DOWN ##1 !clk_run_o)
      else $error("power-down not entered after bit write");
   a_clock_stop: assert property ($past(pd) && pd |-> !clk_run_o) // R2
      else $error("clock running in power-down");
   a_strobe_level: assert property // R3
      (pd |=> (ale_o == $past(q_ff.pctl[PC_STRB_LVL]))
              && (store_strobe_o == $past(q_ff.pctl[PC_STRB_LVL])))
      else $error("strobe level wrong in power-down");
   a_port0_float: assert property (pd && ext_prog_i |=> !port0_oe_o) // R4
      else $error("port 0 driven in power-down");
   a_pin_wake: assert property // R5
      (pd && q_ff.sync2[0] |-> ##2 cpu_reset_o && clk_run_o)
      else $error("reset pin did not end power-down");
   a_wdt_frozen: assert property (pd && $past(pd) |-> $stable(q_ff.grace)) // R6
      else $error("watchdog advanced in power-down");
   a_int_wake: assert property // R7
      (pd && !chip_rst && wake_pins != 2'b00 |=> q_ff.pwr == PWR_WAKE)
      else $error("enabled interrupt did not wake");
   a_wake_request: assert property // R8
      (q_ff.pwr == PWR_WAKE |=> (wake_int0_o || wake_int1_o) && clk_run_o)
      else $error("wake without interrupt request");
   a_timeout_flag: assert property (!pd && !chip_rst && wdt_timeout_i |=> q_ff.wd[WD_TOF]) // R13
      else $error("timeout flag not set");
   a_wdt_hold_len: assert property // R14
      ($rose(q_ff.wdt_hold) && !por_now |-> q_ff.wdt_hold [*8] ##1 !q_ff.wdt_hold)
      else $error("watchdog reset length wrong");
   a_wdt_flag: assert property (q_ff.wdt_hold && !por_now |=> q_ff.wd[WD_RSTF]) // R19
      else $error("watchdog reset flag not set");
   a_por_flags: assert property // R12
      (por_now |=> q_ff.wd[WD_POR] && !q_ff.wd[WD_REN] && !q_ff.wd[WD_RSTF])
      else $error("power-on flags wrong");
   a_ext_flags: assert property // R18
      (ext_hold && !por_now && !q_ff.wdt_hold |=> !q_ff.wd[WD_TOF] && !q_ff.wd[WD_RESTART]
       && q_ff.wd[WD_RSTF] == $past(q_ff.wd[WD_RSTF]))
      else $error("external reset pattern wrong");
   a_port_reset: assert property // R16
      (chip_rst |=> port_o == PORT_RESET && start_sp_o == SP_START)
      else $error("reset values not loaded");
   a_locked_bits: assert property // R21
      ((wr && wb_adr_i == ADR_WDCTL && !q_ff.unl_open && !chip_rst && !q_ff.sync1[1])
       |=> $stable(q_ff.wd[WD_POR]) && $stable(q_ff.wd[WD_REN]))
      else $error("protected bit written while locked");

   c_pdown: cover property (q_ff.pwr == PWR_RUN ##1 pd);
   c_int_wake: cover property (q_ff.pwr == PWR_WAKE ##1 wake_int0_o);
   c_pin_wake: cover property (pd ##1 ext_hold);
   c_wdt_reset: cover property ($rose(q_ff.wdt_hold));

endmodule : powerdown_and_reset_control
`default_nettype wire

// File: ext_sources.sv
// model of the reset pin, supply detector and interrupt pin sources
`timescale 1ns/1ps
`default_nettype none
module ext_sources
(
   input  wire logic clk_i,
   output var  logic reset_pin_o,
   output var  logic supply_low_o,
   output var  logic int0_n_o,
   output var  logic int1_n_o
);
   initial
   begin
      reset_pin_o  = 1'b0;
      supply_low_o = 1'b0;
      int0_n_o     = 1'b1;
      int1_n_o     = 1'b1;
   end
   task automatic pin_pulse(input int n);
      @(posedge clk_i);
      reset_pin_o <= 1'b1;
      repeat ((n < 8) ? 8 : n) @(posedge clk_i);
      reset_pin_o <= 1'b0;
   endtask : pin_pulse
   task automatic supply_dip(input int n);
      @(posedge clk_i);
      supply_low_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      supply_low_o <= 1'b0;
   endtask : supply_dip
   task automatic set_int(input logic i0, input logic i1);
      @(posedge clk_i);
      int0_n_o <= i0;
      int1_n_o <= i1;
   endtask : set_int
endmodule : ext_sources
`default_nettype wire

// File: tb.sv
// self-checking bench of the power-down and reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
   import pwr_rst_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc   = 1'b0;
   logic        we    = 1'b0;
   logic        wdt   = 1'b0;
   logic        ale_c = 1'b0;
   logic        psn_c = 1'b0;
   logic        xprog = 1'b0;
   logic [7:0]  adr   = 8'h00;
   logic [3:0]  sel   = 4'h0;
   logic [31:0] wdat  = 32'h0;
   logic [31:0] rd, dat_o, port;
   logic [15:0] spc;
   logic [7:0]  ssp;
   logic        ack, run, crst, ale, pss, oe0, wren, wrs, w0, w1, rpin, sup, i0n, i1n;
   int          fails = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          hi, first, n0, n1, nr;
   always #25 clk_i = ~clk_i;
   ext_sources u_src (.clk_i(clk_i), .reset_pin_o(rpin), .supply_low_o(sup),
      .int0_n_o(i0n), .int1_n_o(i1n));
   powerdown_and_reset_control #(.GRACE_CLKS(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .reset_pin_i(rpin),
      .supply_low_i(sup), .int0_n_i(i0n), .int1_n_i(i1n), .wdt_timeout_i(wdt),
      .ale_core_i(ale_c), .store_strobe_core_i(psn_c), .ext_prog_i(xprog), .clk_run_o(run),
      .cpu_reset_o(crst), .start_pc_o(spc), .start_sp_o(ssp), .ale_o(ale),
      .store_strobe_o(pss),
      .port_o(port), .port0_oe_o(oe0), .wdt_restart_o(wrs), .wdt_reset_enable_o(wren),
      .wake_int0_o(w0), .wake_int1_o(w1));
   task automatic stop_test;
      if (fails == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         stop_test();
      end
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      sel  <= 4'hF;
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      rd = dat_o;
      cyc <= 1'b0;
      we  <= 1'b0;
   endtask : wb
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(nm, e, rd & m)
   endtask : rc
   task automatic unlock;
      wb(1'b1, ADR_UNLOCK, 32'hAA);
      wb(1'b1, ADR_UNLOCK, 32'h55);
   endtask : unlock
   task automatic pulse_wdt;
      @(posedge clk_i);
      wdt <= 1'b1;
      @(posedge clk_i);
      wdt <= 1'b0;
   endtask : pulse_wdt
   // counts reset cycles and wake pulses over n clocks
   task automatic watch(input int n);
      hi = 0;
      first = -1;
      n0 = 0;
      n1 = 0;
      nr = 0;
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk_i);
         #1;
         if (crst === 1'b1 && first < 0)
            first = k;
         hi += (crst === 1'b1);
         n0 += (w0 === 1'b1);
         n1 += (w1 === 1'b1);
         nr += (wrs === 1'b1);
      end
   endtask : watch
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      `CHK("port", PORT_RESET, port)
      `CHK("pc", PC_START, spc)
      `CHK("sp", SP_START, ssp)
      rc("wdctl", ADR_WDCTL, 32'hFF, 32'h40);
      rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
      wb(1'b1, ADR_WDCTL, 32'h06);
      rc("locked", ADR_WDCTL, 32'hFF, 32'h44);
      unlock();
      wb(1'b1, ADR_WDCTL, 32'h02);
      rc("unlocked", ADR_WDCTL, 32'hFF, 32'h02);
      `CHK("wren", 1'b1, wren)
      unlock();
      fork
         wb(1'b1, ADR_WDCTL, 32'h03);
         watch(8);
      join
      `CHK("restart", 1, nr)
      pulse_wdt();
      fork
         rc("tof", ADR_WDCTL, 32'h08, 32'h08);
         watch(60);
      join
      `CHK("wd delay", 1'b1, first >= 15 && first <= 20)
      `CHK("wd hold", WDT_RST_MC * MC_CLKS, hi)
      rc("wd flags", ADR_WDCTL, 32'h06, 32'h06);
      wb(1'b1, ADR_PORTS, 32'h12345678);
      fork
         u_src.pin_pulse(12);
         watch(60);
      join
      `CHK("ext hold", 1'b1, hi >= 8 && hi <= 20)
      `CHK("ext port", PORT_RESET, port)
      rc("ext flags", ADR_WDCTL, 32'h0F, 32'h06);
      xprog <= 1'b1;
      wb(1'b1, ADR_PORTS, 32'hA5A5A5A5);
      wb(1'b1, ADR_INT_EN, 32'h85);
      wb(1'b1, ADR_PWR_CTRL, 32'h12);
      repeat (3) @(posedge clk_i);
      #1;
      `CHK("run", 1'b0, run)
      `CHK("ale", 1'b1, ale)
      `CHK("store strobe", 1'b1, pss)
      `CHK("pd port", 32'hA5A5A5A5, port)
      `CHK("oe0", 1'b0, oe0)
      rc("pd bit", ADR_PWR_CTRL, 32'h02, 32'h02);
      fork
         u_src.set_int(1'b0, 1'b1);
         watch(40);
      join
      `CHK("wake run", 1'b1, run)
      `CHK("wake0", 1, n0)
      `CHK("wake1", 0, n1)
      u_src.set_int(1'b1, 1'b1);
      rc("pd clear", ADR_PWR_CTRL, 32'h02, 32'h00);
      xprog <= 1'b0;
      ale_c <= 1'b1;
      psn_c <= 1'b1;
      wb(1'b1, ADR_INT_EN, 32'h81);
      wb(1'b1, ADR_PWR_CTRL, 32'h02);
      u_src.set_int(1'b1, 1'b0);
      pulse_wdt();
      watch(40);
      `CHK("pd wdt", 0, hi)
      `CHK("masked", 1'b0, run)
      `CHK("ale lo", 1'b0, ale)
      `CHK("store strobe lo", 1'b0, pss)
      `CHK("oe0 int", 1'b1, oe0)
      u_src.set_int(1'b1, 1'b1);
      fork
         u_src.pin_pulse(12);
         watch(60);
      join
      `CHK("pin exit", 1'b1, hi > 0)
      `CHK("pin run", 1'b1, run)
      fork
         u_src.supply_dip(12);
         watch(60);
      join
      `CHK("por", 1'b1, hi > 0)
      rc("por flags", ADR_WDCTL, 32'h46, 32'h40);
      `CHK("por wren", 1'b0, wren)
      stop_test();
   end
endmodule : tb
`default_nettype wire
